// ==== verilog/ptp_cfg_pkg.sv ====
package ptp_cfg_pkg;

    // ****************************************************************
    // Register map.
    // ****************************************************************
    localparam logic [4:0]  OFFSET_PAGE_SELECT   = 5'h13;
    localparam logic [4:0]  OFFSET_EVENT_CONFIG  = 5'h15;
    localparam logic [4:0]  OFFSET_TX_CONFIG     = 5'h16;
    localparam logic [2:0]  CONFIG_PAGE          = 3'h5;
    localparam logic [2:0]  PAGE_RESET           = 3'h0;
    localparam logic [15:0] REG_RESET            = 16'h0000;

    // ****************************************************************
    // Event configuration fields.
    // ****************************************************************
    localparam int EV_RISE_BIT   = 14;
    localparam int EV_FALL_BIT   = 13;
    localparam int EV_SINGLE_BIT = 12;
    localparam int EV_ROUTE_HI   = 11;
    localparam int EV_ROUTE_LO   = 8;
    localparam int EV_SEL_HI     = 3;
    localparam int EV_SEL_LO     = 1;
    localparam int EV_WR_BIT     = 0;
    localparam logic [3:0] ROUTE_NONE = 4'h0;

    // ****************************************************************
    // Transmit configuration fields.
    // ****************************************************************
    localparam int TX_ONE_STEP_BIT  = 15;
    localparam int TX_DELAY_REQUEST_TS_INSERT_BIT = 13;
    localparam int TX_NTP_BIT       = 12;
    localparam int TX_IGN_2STEP_BIT = 11;
    localparam int TX_CRC_OVR_BIT   = 10;
    localparam int TX_CHK_FIX_BIT   = 9;
    localparam int TX_IP_FILT_BIT   = 8;
    localparam int TX_L2_BIT        = 7;
    localparam int TX_IPV6_BIT      = 6;
    localparam int TX_IPV4_BIT      = 5;
    localparam int TX_VER_HI        = 4;
    localparam int TX_VER_LO        = 1;
    localparam int TX_CAPTURE_BIT   = 0;
    localparam logic [15:0] TX_WRITE_MASK = 16'hBFFF;
    localparam logic [3:0]  VERSION_ANY   = 4'h0;

    // ****************************************************************
    // Message classification.
    // ****************************************************************
    localparam logic [15:0] PTP_EVENT_PORT = 16'h013F;
    localparam logic [15:0] NTP_PORT       = 16'h007B;
    localparam logic [1:0]  ENCAP_NONE     = 2'h0;
    localparam logic [1:0]  ENCAP_L2       = 2'h1;
    localparam logic [1:0]  ENCAP_IPV4     = 2'h2;
    localparam logic [1:0]  ENCAP_IPV6     = 2'h3;

endpackage : ptp_cfg_pkg

// ==== verilog/ptp_event_tx_timestamp_config.sv ====
// How it works
// - Write with request bit set loads control fields into the selected unit only.
// - Write with request bit clear selects a unit for the next readback.
// - Rise enable makes the unit timestamp rising edges on its routed pin.
// - Fall enable makes the unit timestamp falling edges on its routed pin.
// - Single-capture mode clears both edge enables after one capture.
// - Route field picks pin 1 to 12; zero or above 12 leaves unit unconnected.
// - Reserved bits ignore writes and read as zero.
// - One-step Sync inserts the timestamp and regenerates checksum and CRC.
// - Parsers match port 319 for PTP or port 123 for NTP.
// - Bad incoming CRC is forced bad unless override bit set.
// - Checksum fix rewrites last two UDP bytes, never for Layer2.
// - IP filter drops IP event messages without the assigned destination.
// - Each encapsulation has its own detection enable.
// - Nonzero version field restricts capture to that version.
// - Transmit capture only while capture enable is set.
// - Both registers answer only while page selector holds page five.
`timescale 1ns/1ps

module ptp_event_tx_timestamp_config #(
    parameter int EVENT_UNITS = 8,   // Number of event timestamp units.
    parameter int PIN_COUNT   = 12,  // Number of routable event pins.
    parameter int TS_WIDTH    = 32   // Width of a timestamp.
) (
    input  wire logic                   ref_clk,              // System clock.
    input  wire logic                   rst_n,                // Synchronous reset.
    input  wire logic                   mgmt_wr_en,           // Register write strobe.
    input  wire logic                   mgmt_rd_en,           // Register read strobe.
    input  wire logic [4:0]             mgmt_addr,            // Register address.
    input  wire logic [15:0]            mgmt_wr_data,         // Register write data.
    output logic      [15:0]            mgmt_rd_data,         // Register read data.
    output logic                        mgmt_rd_valid,        // Read data valid.
    input  wire logic [PIN_COUNT-1:0]   event_pins,           // Event pin levels.
    input  wire logic [TS_WIDTH-1:0]    current_time,         // Running clock time.
    output logic      [EVENT_UNITS-1:0] event_capture,        // Event captured pulse.
    output logic      [EVENT_UNITS-1:0] event_rising,         // Captured edge was rising.
    output logic      [TS_WIDTH-1:0]    event_time,           // Time of latest capture.
    input  wire logic                   tx_desc_valid,        // Parsed message pulse.
    input  wire logic [1:0]             tx_desc_encap,        // Encapsulation code.
    input  wire logic [15:0]            tx_desc_udp_port,     // UDP destination port.
    input  wire logic [3:0]             tx_desc_version,      // PTP version.
    input  wire logic                   tx_desc_two_step,     // Two_Step flag.
    input  wire logic                   tx_desc_ip_dst_ptp,   // Destination is PTP address.
    input  wire logic                   tx_desc_is_sync,      // Message is Sync.
    input  wire logic                   tx_desc_is_delay_req, // Message is Delay_Req.
    input  wire logic                   tx_desc_crc_bad,      // Frame CRC was bad.
    output logic                        tx_ts_capture,        // Timestamp taken pulse.
    output logic      [TS_WIDTH-1:0]    tx_ts_value,          // Taken timestamp.
    output logic                        tx_one_step_insert,   // Insert stamp into frame.
    output logic                        tx_crc_regenerate,    // Rebuild frame CRC.
    output logic                        tx_force_crc_error,   // Send deliberately bad CRC.
    output logic                        tx_udp_checksum_fix,  // Rewrite last UDP bytes.
    output logic      [TS_WIDTH-1:0]    delay_req_time,       // Latest Delay_Req stamp.
    output logic                        delay_resp_insert_en, // Receive insert enable.
    output logic      [15:0]            event_port_match      // Port for both parsers.
);

    // ****************************************************************
    // Register decode.
    // ****************************************************************
    logic [2:0]  register_page_selector;
    logic [15:0] transmit_timestamp_config;
    logic [2:0]  event_unit_selector;
    logic        page_ok;
    logic        ev_write;
    logic        tx_write;
    logic        ev_commit;

    logic [EVENT_UNITS-1:0] rise_detect_enable;
    logic [EVENT_UNITS-1:0] fall_detect_enable;
    logic [EVENT_UNITS-1:0] single_capture_mode;
    logic [3:0]             event_pin_route [EVENT_UNITS];
    logic [EVENT_UNITS-1:0] next_capture;
    logic [EVENT_UNITS-1:0] next_rising;

    assign page_ok   = register_page_selector == ptp_cfg_pkg::CONFIG_PAGE;
    assign ev_write  = mgmt_wr_en && page_ok && mgmt_addr == ptp_cfg_pkg::OFFSET_EVENT_CONFIG;
    assign tx_write  = mgmt_wr_en && page_ok && mgmt_addr == ptp_cfg_pkg::OFFSET_TX_CONFIG;
    assign ev_commit = ev_write && mgmt_wr_data[ptp_cfg_pkg::EV_WR_BIT];

    // Returns the level of the routed pin, or zero for an unconnected unit.
    function automatic logic pin_level(input logic [3:0] route,
                                       input logic [PIN_COUNT-1:0] pins);
        logic level;
        level = 1'b0;
        for (int p = 1; p <= PIN_COUNT; p++) begin
            if (route == 4'(p)) begin
                level = pins[p-1];
            end
        end
        return level;
    endfunction : pin_level

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            register_page_selector <= ptp_cfg_pkg::PAGE_RESET;
        end else if (mgmt_wr_en && mgmt_addr == ptp_cfg_pkg::OFFSET_PAGE_SELECT) begin
            register_page_selector <= mgmt_wr_data[2:0];
        end
    end

    // The selector is stored on every event write, so a plain select with
    // the request bit clear only aims the next readback.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            event_unit_selector <= 3'h0;
        end else if (ev_write) begin
            event_unit_selector <=
                mgmt_wr_data[ptp_cfg_pkg::EV_SEL_HI:ptp_cfg_pkg::EV_SEL_LO];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            transmit_timestamp_config <= ptp_cfg_pkg::REG_RESET;
        end else if (tx_write) begin
            transmit_timestamp_config <= mgmt_wr_data & ptp_cfg_pkg::TX_WRITE_MASK;
        end
    end

    // ****************************************************************
    // Event timestamp units.
    // ****************************************************************
    for (genvar u = 0; u < EVENT_UNITS; u++) begin : g_unit
        logic hit;
        logic level;
        logic level_prev;
        logic rise_edge;
        logic fall_edge;
        logic capture;

        assign hit       = ev_commit &&
                           mgmt_wr_data[ptp_cfg_pkg::EV_SEL_HI:ptp_cfg_pkg::EV_SEL_LO] == 3'(u);
        assign level     = pin_level(event_pin_route[u], event_pins);
        assign rise_edge = level && !level_prev && rise_detect_enable[u];
        assign fall_edge = !level && level_prev && fall_detect_enable[u];
        assign capture   = rise_edge || fall_edge;
        assign next_capture[u] = capture;
        assign next_rising[u]  = rise_edge;

        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                level_prev <= 1'b0;
            end else begin
                level_prev <= level;
            end
        end

        // A host write committed to this unit in the same cycle as a single capture takes priority.
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                rise_detect_enable[u]  <= 1'b0;
                fall_detect_enable[u]  <= 1'b0;
                single_capture_mode[u] <= 1'b0;
                event_pin_route[u]     <= ptp_cfg_pkg::ROUTE_NONE;
            end else if (hit) begin
                rise_detect_enable[u]  <= mgmt_wr_data[ptp_cfg_pkg::EV_RISE_BIT];
                fall_detect_enable[u]  <= mgmt_wr_data[ptp_cfg_pkg::EV_FALL_BIT];
                single_capture_mode[u] <= mgmt_wr_data[ptp_cfg_pkg::EV_SINGLE_BIT];
                event_pin_route[u]     <=
                    mgmt_wr_data[ptp_cfg_pkg::EV_ROUTE_HI:ptp_cfg_pkg::EV_ROUTE_LO];
            end else if (capture && single_capture_mode[u]) begin
                rise_detect_enable[u]  <= 1'b0;
                fall_detect_enable[u]  <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            event_capture <= '0;
            event_rising  <= '0;
        end else begin
            event_capture <= next_capture;
            event_rising  <= next_rising;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            event_time <= '0;
        end else if (|next_capture) begin
            event_time <= current_time;
        end
    end

    // ****************************************************************
    // Register readback.
    // ****************************************************************
    logic [15:0] ev_readback;
    logic [15:0] next_rd_data;

    always_comb begin
        ev_readback = 16'h0000;
        ev_readback[ptp_cfg_pkg::EV_RISE_BIT]   = rise_detect_enable[event_unit_selector];
        ev_readback[ptp_cfg_pkg::EV_FALL_BIT]   = fall_detect_enable[event_unit_selector];
        ev_readback[ptp_cfg_pkg::EV_SINGLE_BIT] = single_capture_mode[event_unit_selector];
        ev_readback[ptp_cfg_pkg::EV_ROUTE_HI:ptp_cfg_pkg::EV_ROUTE_LO] =
            event_pin_route[event_unit_selector];
        ev_readback[ptp_cfg_pkg::EV_SEL_HI:ptp_cfg_pkg::EV_SEL_LO] = event_unit_selector;
        ev_readback[ptp_cfg_pkg::EV_WR_BIT] = 1'b0;
    end

    always_comb begin
        next_rd_data = 16'h0000;
        if (mgmt_addr == ptp_cfg_pkg::OFFSET_PAGE_SELECT) begin
            next_rd_data = {13'h0000, register_page_selector};
        end else if (page_ok && mgmt_addr == ptp_cfg_pkg::OFFSET_EVENT_CONFIG) begin
            next_rd_data = ev_readback;
        end else if (page_ok && mgmt_addr == ptp_cfg_pkg::OFFSET_TX_CONFIG) begin
            next_rd_data = transmit_timestamp_config;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mgmt_rd_data  <= 16'h0000;
            mgmt_rd_valid <= 1'b0;
        end else begin
            mgmt_rd_valid <= mgmt_rd_en;
            if (mgmt_rd_en) begin
                mgmt_rd_data <= next_rd_data;
            end
        end
    end

    // ****************************************************************
    // Transmit classification.
    // ****************************************************************
    logic [15:0] match_port;
    logic        encap_ok;
    logic        is_ip;
    logic        port_ok;
    logic        version_ok;
    logic        ip_ok;
    logic        take_stamp;
    logic        insert;
    logic [3:0]  cfg_version;

    assign cfg_version = transmit_timestamp_config[ptp_cfg_pkg::TX_VER_HI:ptp_cfg_pkg::TX_VER_LO];
    assign match_port  = transmit_timestamp_config[ptp_cfg_pkg::TX_NTP_BIT] ?
                         ptp_cfg_pkg::NTP_PORT : ptp_cfg_pkg::PTP_EVENT_PORT;
    assign is_ip       = tx_desc_encap == ptp_cfg_pkg::ENCAP_IPV4 ||
                         tx_desc_encap == ptp_cfg_pkg::ENCAP_IPV6;

    always_comb begin
        case (tx_desc_encap)
            ptp_cfg_pkg::ENCAP_L2:   encap_ok = transmit_timestamp_config[ptp_cfg_pkg::TX_L2_BIT];
            ptp_cfg_pkg::ENCAP_IPV6: encap_ok =
                transmit_timestamp_config[ptp_cfg_pkg::TX_IPV6_BIT];
            ptp_cfg_pkg::ENCAP_IPV4: encap_ok =
                transmit_timestamp_config[ptp_cfg_pkg::TX_IPV4_BIT];
            default:                 encap_ok = 1'b0;
        endcase
    end

    assign port_ok    = !is_ip || tx_desc_udp_port == match_port;
    assign version_ok = cfg_version == ptp_cfg_pkg::VERSION_ANY ||
                        cfg_version == tx_desc_version;
    assign ip_ok      = !is_ip || !transmit_timestamp_config[ptp_cfg_pkg::TX_IP_FILT_BIT] ||
                        tx_desc_ip_dst_ptp;
    assign take_stamp = tx_desc_valid && transmit_timestamp_config[ptp_cfg_pkg::TX_CAPTURE_BIT] &&
                        encap_ok && port_ok && version_ok && ip_ok;
    assign insert     = take_stamp && tx_desc_is_sync &&
                        transmit_timestamp_config[ptp_cfg_pkg::TX_ONE_STEP_BIT] &&
                        (transmit_timestamp_config[ptp_cfg_pkg::TX_IGN_2STEP_BIT] ||
                         !tx_desc_two_step);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_ts_capture       <= 1'b0;
            tx_one_step_insert  <= 1'b0;
            tx_crc_regenerate   <= 1'b0;
            tx_force_crc_error  <= 1'b0;
            tx_udp_checksum_fix <= 1'b0;
        end else begin
            tx_ts_capture       <= take_stamp;
            tx_one_step_insert  <= insert;
            tx_crc_regenerate   <= insert;
            tx_force_crc_error  <= insert && tx_desc_crc_bad &&
                !transmit_timestamp_config[ptp_cfg_pkg::TX_CRC_OVR_BIT];
            // Relies on the MAC sending the last two UDP bytes as zeros.
            tx_udp_checksum_fix <= insert && is_ip &&
                transmit_timestamp_config[ptp_cfg_pkg::TX_CHK_FIX_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_ts_value <= '0;
        end else if (take_stamp) begin
            tx_ts_value <= current_time;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            delay_req_time <= '0;
        end else if (take_stamp && tx_desc_is_delay_req) begin
            delay_req_time <= current_time;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            delay_resp_insert_en <= 1'b0;
            event_port_match     <= ptp_cfg_pkg::PTP_EVENT_PORT;
        end else begin
            delay_resp_insert_en <=
                transmit_timestamp_config[ptp_cfg_pkg::TX_DELAY_REQUEST_TS_INSERT_BIT];
            event_port_match     <= match_port;
        end
    end

endmodule : ptp_event_tx_timestamp_config

// ==== dv/ptp_cfg_asserts.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Port checks for the configuration block.
// ****************************************************************
module ptp_cfg_asserts #(
    parameter int EVENT_UNITS = 8,  // Event units.
    parameter int PIN_COUNT   = 12, // Event pins.
    parameter int TS_WIDTH    = 32  // Timestamp width.
) (
    input wire logic                ref_clk,             // Clock.
    input wire logic                rst_n,               // Reset.
    input wire logic                mgmt_rd_en,          // Read strobe.
    input wire logic [4:0]          mgmt_addr,           // Address.
    input wire logic [15:0]         mgmt_rd_data,        // Read data.
    input wire logic                mgmt_rd_valid,       // Read valid.
    input wire logic [TS_WIDTH-1:0] current_time,        // Running time.
    input wire logic                tx_desc_valid,       // Descriptor pulse.
    input wire logic                tx_ts_capture,       // Stamp pulse.
    input wire logic [TS_WIDTH-1:0] tx_ts_value,         // Stamp value.
    input wire logic                tx_one_step_insert,  // Insert pulse.
    input wire logic                tx_crc_regenerate,   // CRC rebuild.
    input wire logic                tx_force_crc_error,  // Forced bad CRC.
    input wire logic                tx_udp_checksum_fix, // Checksum fix.
    input wire logic [15:0]         event_port_match     // Parser port.
);
    logic [4:0] rd_addr_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            rd_addr_q <= 5'h00;
        else if (mgmt_rd_en)
            rd_addr_q <= mgmt_addr;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_desc_taken;
        tx_desc_valid ##1 tx_ts_capture;
    endsequence

    a_read_answer: assert property (mgmt_rd_en |=> mgmt_rd_valid)
        else $error("read gave no answer one cycle later");
    a_read_single: assert property (!mgmt_rd_en |=> !mgmt_rd_valid)
        else $error("read valid without a read");
    a_event_reserved: assert property (mgmt_rd_valid && rd_addr_q == 5'h15
        |-> (mgmt_rd_data & 16'h80F1) == 16'h0000) else $error("event reserved bits set");
    a_tx_reserved: assert property (mgmt_rd_valid && rd_addr_q == 5'h16
        |-> !mgmt_rd_data[14]) else $error("transmit reserved bit set");
    a_insert_paired: assert property (tx_one_step_insert
        |-> tx_crc_regenerate && tx_ts_capture) else $error("insert without stamp or crc");
    a_crc_force_cause: assert property (tx_force_crc_error |-> tx_one_step_insert)
        else $error("forced crc error without insert");
    a_fix_cause: assert property (tx_udp_checksum_fix |-> tx_one_step_insert)
        else $error("checksum fix without insert");
    a_capture_cause: assert property (!tx_desc_valid |=> !tx_ts_capture)
        else $error("stamp without descriptor");
    a_stamp_time: assert property (s_desc_taken
        |-> tx_ts_value == $past(current_time)) else $error("stamp value wrong");
    a_port_choice: assert property (mgmt_rd_valid && rd_addr_q == 5'h16
        && mgmt_rd_data[12] |-> event_port_match == 16'h007B) else $error("parser port not NTP");
endmodule : ptp_cfg_asserts

bind ptp_event_tx_timestamp_config ptp_cfg_asserts #(.EVENT_UNITS(EVENT_UNITS),
    .PIN_COUNT(PIN_COUNT), .TS_WIDTH(TS_WIDTH)) i_asserts (.ref_clk, .rst_n, .mgmt_rd_en,
    .mgmt_addr, .mgmt_rd_data, .mgmt_rd_valid, .current_time, .tx_desc_valid, .tx_ts_capture,
    .tx_ts_value, .tx_one_step_insert, .tx_crc_regenerate, .tx_force_crc_error,
    .tx_udp_checksum_fix, .event_port_match);

// ==== dv/mac_tx_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Transmit path model: hands one parsed message per call.
// ****************************************************************
module mac_tx_model (
    input  wire logic ref_clk,              // Clock.
    output logic      tx_desc_valid,        // Descriptor pulse.
    output logic [1:0]  tx_desc_encap,      // Encapsulation.
    output logic [15:0] tx_desc_udp_port,   // UDP port.
    output logic [3:0]  tx_desc_version,    // Version.
    output logic      tx_desc_two_step,     // Two_Step flag.
    output logic      tx_desc_ip_dst_ptp,   // PTP destination.
    output logic      tx_desc_is_sync,      // Sync.
    output logic      tx_desc_is_delay_req, // Delay_Req.
    output logic      tx_desc_crc_bad       // Bad CRC.
);
    initial begin
        tx_desc_valid = 1'b0;
        {tx_desc_encap, tx_desc_udp_port, tx_desc_version} = 22'h0;
        {tx_desc_two_step, tx_desc_ip_dst_ptp, tx_desc_is_sync} = 3'h0;
        {tx_desc_is_delay_req, tx_desc_crc_bad} = 2'h0;
    end

    // Payload tail bytes go out as zeros; only descriptors are modelled.
    task send(input logic [1:0] enc, input logic [15:0] port, input logic [3:0] ver,
              input logic [4:0] fl);
        @(posedge ref_clk);
        #1;
        tx_desc_valid = 1'b1;
        {tx_desc_encap, tx_desc_udp_port, tx_desc_version} = {enc, port, ver};
        {tx_desc_two_step, tx_desc_ip_dst_ptp, tx_desc_is_sync} = fl[4:2];
        {tx_desc_is_delay_req, tx_desc_crc_bad} = fl[1:0];
        @(posedge ref_clk);
        #1;
        tx_desc_valid = 1'b0;
        {tx_desc_encap, tx_desc_udp_port, tx_desc_version} = ~{enc, port, ver};
        {tx_desc_two_step, tx_desc_ip_dst_ptp, tx_desc_is_sync} = ~fl[4:2];
        {tx_desc_is_delay_req, tx_desc_crc_bad} = ~fl[1:0];
    endtask : send
endmodule : mac_tx_model

// ==== dv/test_ptp_event_tx_timestamp_config.sv ====
`timescale 1ns/1ps
module test_ptp_event_tx_timestamp_config;
    localparam logic [4:0] EV = ptp_cfg_pkg::OFFSET_EVENT_CONFIG;
    localparam logic [4:0] TX = ptp_cfg_pkg::OFFSET_TX_CONFIG;
    localparam logic [1:0] L2 = ptp_cfg_pkg::ENCAP_L2;
    localparam logic [1:0] V4 = ptp_cfg_pkg::ENCAP_IPV4, V6 = ptp_cfg_pkg::ENCAP_IPV6;
    localparam logic [15:0] P319 = ptp_cfg_pkg::PTP_EVENT_PORT, P123 = ptp_cfg_pkg::NTP_PORT;
    logic ref_clk = 1'b0, rst_n = 1'b0, mgmt_wr_en = 1'b0, mgmt_rd_en = 1'b0;
    logic [4:0] mgmt_addr = 5'h00;
    logic [15:0] mgmt_wr_data = 16'h0000, mgmt_rd_data, event_port_match, tx_desc_udp_port;
    logic [11:0] event_pins = 12'h000;
    logic [31:0] current_time = 32'h0, event_time, tx_ts_value, delay_req_time;
    logic [7:0] event_capture, event_rising;
    logic mgmt_rd_valid, tx_desc_valid, tx_desc_two_step, tx_desc_ip_dst_ptp, tx_desc_is_sync;
    logic tx_desc_is_delay_req, tx_desc_crc_bad, tx_ts_capture, tx_one_step_insert;
    logic tx_crc_regenerate, tx_force_crc_error, tx_udp_checksum_fix, delay_resp_insert_en;
    logic [1:0] tx_desc_encap;
    logic [3:0] tx_desc_version;
    int mismatches = 0, checks_done = 0;

    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) current_time <= current_time + 32'h1;

    ptp_event_tx_timestamp_config i_dut (.ref_clk, .rst_n, .mgmt_wr_en, .mgmt_rd_en, .mgmt_addr,
        .mgmt_wr_data, .mgmt_rd_data, .mgmt_rd_valid, .event_pins, .current_time, .event_capture,
        .event_rising, .event_time, .tx_desc_valid, .tx_desc_encap, .tx_desc_udp_port,
        .tx_desc_version, .tx_desc_two_step, .tx_desc_ip_dst_ptp, .tx_desc_is_sync,
        .tx_desc_is_delay_req, .tx_desc_crc_bad, .tx_ts_capture, .tx_ts_value,
        .tx_one_step_insert, .tx_crc_regenerate, .tx_force_crc_error, .tx_udp_checksum_fix,
        .delay_req_time, .delay_resp_insert_en, .event_port_match);
    mac_tx_model i_mac (.ref_clk, .tx_desc_valid, .tx_desc_encap, .tx_desc_udp_port,
        .tx_desc_version, .tx_desc_two_step, .tx_desc_ip_dst_ptp, .tx_desc_is_sync,
        .tx_desc_is_delay_req, .tx_desc_crc_bad);

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        #1;
        {mgmt_wr_en, mgmt_addr, mgmt_wr_data} = {1'b1, a, d};
        @(posedge ref_clk);
        #1;
        mgmt_wr_en = 1'b0;
    endtask : wr

    task rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        #1;
        {mgmt_rd_en, mgmt_addr} = {1'b1, a};
        @(posedge ref_clk);
        #1;
        mgmt_rd_en = 1'b0;
        chk("rd_valid", 32'h1, 32'(mgmt_rd_valid));
        chk("rd_data", 32'(e), 32'(mgmt_rd_data));
    endtask : rd

    task ev(input int pin, input logic lvl, input logic [7:0] emask, input logic [7:0] erise);
        logic [7:0] seen, rise;
        {seen, rise} = 16'h0000;
        @(posedge ref_clk);
        #1;
        event_pins[pin-1] = lvl;
        repeat (4) begin
            @(posedge ref_clk);
            #1;
            seen |= event_capture;
            rise |= event_capture & event_rising;
            if (|event_capture)
                chk("event_time", current_time - 32'h1, event_time);
        end
        chk("event_capture", 32'(emask), 32'(seen));
        chk("event_rising", 32'(erise), 32'(rise));
    endtask : ev

    task txc(input logic [15:0] cfg, input logic [1:0] enc, input logic [15:0] port,
             input logic [3:0] ver, input logic [4:0] fl, input logic [3:0] exp);
        wr(TX, cfg);
        i_mac.send(enc, port, ver, fl);
        chk("tx_flags", 32'({exp[3:2], exp[2:0]}), 32'({tx_ts_capture, tx_one_step_insert,
            tx_crc_regenerate, tx_force_crc_error, tx_udp_checksum_fix}));
        if (exp[3])
            chk("tx_ts_value", current_time - 32'h1, tx_ts_value);
    endtask : txc

    task conclude();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    initial begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        conclude();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        chk("port_match", 32'h013F, 32'(event_port_match));
        wr(TX, 16'hFFFF);
        wr(ptp_cfg_pkg::OFFSET_PAGE_SELECT, 16'h0005);
        rd(ptp_cfg_pkg::OFFSET_PAGE_SELECT, 16'h0005);
        rd(TX, 16'h0000);
        rd(EV, 16'h0000);
        wr(TX, 16'hFFFF);
        rd(TX, 16'hBFFF);
        rd(5'h1F, 16'h0000);
        wr(EV, 16'h4103);
        rd(EV, 16'h4102);
        wr(EV, 16'hB2F5);
        rd(EV, 16'h3204);
        wr(EV, 16'h4D07);
        wr(EV, 16'h0002);
        rd(EV, 16'h4102);
        ev(1, 1'b1, 8'h02, 8'h02);
        ev(2, 1'b1, 8'h00, 8'h00);
        ev(2, 1'b0, 8'h04, 8'h00);
        wr(EV, 16'h0004);
        rd(EV, 16'h1204);
        ev(2, 1'b1, 8'h00, 8'h00);
        ev(2, 1'b0, 8'h00, 8'h00);
        ev(1, 1'b0, 8'h00, 8'h00);
        for (int p = 3; p <= 12; p++)
            ev(p, 1'b1, 8'h00, 8'h00);
        txc(16'h80E5, L2, 16'h0000, 4'h2, 5'b00100, 4'b1100);
        txc(16'h80E5, V4, P319, 4'h2, 5'b10100, 4'b1000);
        txc(16'h80E5, V4, P123, 4'h2, 5'b00100, 4'b0000);
        txc(16'h80E5, V6, P319, 4'h1, 5'b00100, 4'b0000);
        txc(16'h80E5, V6, P319, 4'h2, 5'b00101, 4'b1110);
        txc(16'h9FE5, V4, P123, 4'h2, 5'b11101, 4'b1101);
        chk("port_match", 32'h007B, 32'(event_port_match));
        txc(16'h9FE5, V6, P123, 4'h2, 5'b00100, 4'b0000);
        txc(16'h9FE5, L2, 16'h0000, 4'h2, 5'b00100, 4'b1100);
        txc(16'h80E4, L2, 16'h0000, 4'h2, 5'b00100, 4'b0000);
        txc(16'h8065, L2, 16'h0000, 4'h2, 5'b00100, 4'b0000);
        txc(16'h2081, L2, 16'h0000, 4'h7, 5'b00010, 4'b1000);
        chk("dreq_time", current_time - 32'h1, delay_req_time);
        chk("dresp_en", 32'h1, 32'(delay_resp_insert_en));
        chk("port_match", 32'h013F, 32'(event_port_match));
        conclude();
    end
endmodule : test_ptp_event_tx_timestamp_config
